// ---- verilog/adctr_pkg.sv ----
// package: register map, field layout and carrier types for the converter register block
package adctr_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_CHAN0_RESULT_LOW   = 14'h12A0;
  localparam logic [13:0] IDX_CHAN0_RESULT_HIGH  = 14'h12A1;
  localparam logic [13:0] IDX_CHAN1_RESULT_LOW   = 14'h12A2;
  localparam logic [13:0] IDX_CHAN1_RESULT_HIGH  = 14'h12A3;
  localparam logic [13:0] IDX_CONV_MODE_TWO      = 14'h12BA;
  localparam logic [13:0] IDX_IRQ_STATUS         = 14'h12C0;
  localparam logic [13:0] IDX_IRQ_CLEAR          = 14'h12C1;
  localparam logic [13:0] IDX_IRQ_ENABLE         = 14'h12C2;

  localparam int          ADDR_LSB               = 2;
  localparam int          RESULT_W               = 10;
  localparam int          REG_W                  = 8;
  localparam int          MAX_CHAN               = 2;

  // field positions
  localparam int          LOW_RESULT_MSB         = 7;
  localparam int          LOW_RESULT_LSB         = 6;
  localparam int          LOW_FLAG_BIT           = 0;
  localparam int          HIGH_RESULT_SHIFT      = 2;
  localparam int          TRIG_ENABLE_BIT        = 0;
  localparam logic [7:0]  LOW_UNUSED_ONES        = 8'h3E;
  localparam logic [7:0]  MODE_TWO_RESET         = 8'h00;

  // interrupt layout: one stored-result event per channel, then trigger start
  localparam int          IRQ_W                  = 3;
  localparam int          IRQ_TRIG_BIT           = 2;
  localparam logic [2:0]  IRQ_RESET              = 3'h0;

  typedef struct packed {
    logic                valid;
    logic                channel;
    logic [9:0]          data;
  } adctr_result_t;

  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [3:0]          sel;
    logic [15:0]         adr;
    logic [31:0]         dat;
  } adctr_wb_req_t;

endpackage : adctr_pkg

// ---- verilog/adctr_regs.sv ----
// converter trigger gating and channel result registers behind a wishbone slave
// Operation
// [RL1] external trigger starts a conversion only while trigger enable bit is set
// [RL2] software avoids channel code 1011 while external trigger is enabled
// [RL3] two lowest result bits sit in bits 7 and 6 of low register
// [RL4] result bits 9 to 2 sit in bits 7 to 0 of high register
// [RL5] storing a new result sets that channel's stored flag
// [RL6] reading either register of a channel pair clears its stored flag
// [RL7] flags reset to zero; unused mode bits reset to zero
`timescale 1ns/1ps
`default_nettype none

module adctr_regs #(
  parameter int NumChan = 2
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire adctr_pkg::adctr_wb_req_t wbReq,
  output logic [31:0]                  wbDatO,
  output logic                         wbAck,
  input  wire logic                    extTriggerPinN,
  output logic                         convStart,
  input  wire adctr_pkg::adctr_result_t convResult,
  output logic                         extTriggerEnable,
  output logic                         irq
);

  // the channel field is one bit wide, so two channels at the most
  if (NumChan < 1 || NumChan > adctr_pkg::MAX_CHAN)
  begin : g_bad_num_chan
    $error("NumChan must lie between 1 and MAX_CHAN");
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic                              ackQ;
  logic [31:0]                       datQ;
  logic [13:0]                       regIdx;
  logic                              access;
  logic                              wrStrobe;
  logic                              rdStrobe;

  assign regIdx   = wbReq.adr[15:adctr_pkg::ADDR_LSB];
  assign access   = wbReq.cyc && wbReq.stb;
  // effects happen at the edge where the master sees ack
  assign wrStrobe = access && ackQ && wbReq.we;
  assign rdStrobe = access && ackQ && !wbReq.we;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      ackQ <= 1'b0;
    else
      ackQ <= access && !ackQ;
  end

  assign wbAck  = ackQ;
  assign wbDatO = datQ;

  ////////////////////////////////////////////////////////////////////////////
  // trigger pin: synchroniser, falling edge, gating

  logic                              trigSync1Q;
  logic                              trigSync2Q;
  logic                              trigPrevQ;
  logic                              trigEdge;
  logic [7:0]                        modeTwoQ;
  logic                              convStartQ;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trigSync1Q <= 1'b1;
      trigSync2Q <= 1'b1;
      trigPrevQ  <= 1'b1;
    end
    else
    begin
      trigSync1Q <= extTriggerPinN;
      trigSync2Q <= trigSync1Q;
      trigPrevQ  <= trigSync2Q;
    end
  end

  // pin is active low: the request is the high-to-low transition
  assign trigEdge = trigPrevQ && !trigSync2Q;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      convStartQ <= 1'b0;
    else
      convStartQ <= trigEdge && modeTwoQ[adctr_pkg::TRIG_ENABLE_BIT]; // RL1
  end

  assign convStart        = convStartQ;
  assign extTriggerEnable = modeTwoQ[adctr_pkg::TRIG_ENABLE_BIT];

  // only the enable bit is storage; the rest always write zero
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      modeTwoQ <= adctr_pkg::MODE_TWO_RESET; // RL7
    else if (wrStrobe && wbReq.sel[0] && regIdx == adctr_pkg::IDX_CONV_MODE_TWO)
      modeTwoQ <= {7'h00, wbReq.dat[adctr_pkg::TRIG_ENABLE_BIT]}; // RL7
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel result pair and stored flag

  logic [adctr_pkg::RESULT_W-1:0]    resultQ [NumChan];
  logic [NumChan-1:0]                storedFlagQ;
  logic [NumChan-1:0]                landed;
  logic [NumChan-1:0]                pairRead;

  genvar ch;
  generate
    for (ch = 0; ch < NumChan; ch++)
    begin : g_chan
      localparam logic [13:0] LowIdx  = adctr_pkg::IDX_CHAN0_RESULT_LOW + 14'(2 * ch);
      localparam logic [13:0] HighIdx = adctr_pkg::IDX_CHAN0_RESULT_HIGH + 14'(2 * ch);

      assign landed[ch]   = convResult.valid && (32'(convResult.channel) == ch);
      assign pairRead[ch] = rdStrobe && (regIdx == LowIdx || regIdx == HighIdx);

      // result bits are not reset: undefined until the first conversion
      always_ff @(posedge sys_clk)
      begin
        if (landed[ch])
          resultQ[ch] <= convResult.data;
      end

      // a result landing in the clearing read's cycle keeps the flag set
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          storedFlagQ[ch] <= 1'b0; // RL7
        else if (landed[ch])
          storedFlagQ[ch] <= 1'b1; // RL5
        else if (pairRead[ch])
          storedFlagQ[ch] <= 1'b0; // RL6
      end

      // every channel, not only the first, must follow the read-clear rule
      flag_own_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
        pairRead[ch] && !landed[ch] |=> !storedFlagQ[ch])
        else $error("pair read left the stored flag set");

      // a read of the other pair or any write must leave the flag alone
      flag_keep_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
        storedFlagQ[ch] && !pairRead[ch] |=> storedFlagQ[ch])
        else $error("stored flag cleared without a pair read");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, clear and enable

  logic [adctr_pkg::IRQ_W-1:0]       irqStatusQ;
  logic [adctr_pkg::IRQ_W-1:0]       irqEnableQ;
  logic [adctr_pkg::IRQ_W-1:0]       irqEvent;
  logic [adctr_pkg::IRQ_W-1:0]       irqClear;

  always_comb
  begin
    irqEvent = '0;
    irqEvent[NumChan-1:0] = landed;
    irqEvent[adctr_pkg::IRQ_TRIG_BIT] = convStartQ;
  end

  assign irqClear = (wrStrobe && wbReq.sel[0] && regIdx == adctr_pkg::IDX_IRQ_CLEAR)
                    ? wbReq.dat[adctr_pkg::IRQ_W-1:0] : '0;

  // set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irqStatusQ <= adctr_pkg::IRQ_RESET;
    else
      irqStatusQ <= (irqStatusQ & ~irqClear) | irqEvent;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irqEnableQ <= adctr_pkg::IRQ_RESET;
    else if (wrStrobe && wbReq.sel[0] && regIdx == adctr_pkg::IDX_IRQ_ENABLE)
      irqEnableQ <= wbReq.dat[adctr_pkg::IRQ_W-1:0];
  end

  assign irq = |(irqStatusQ & irqEnableQ);

  ////////////////////////////////////////////////////////////////////////////
  // read mux, captured together with ack

  logic [31:0]                       rdData;

  always_comb
  begin
    rdData = 32'h0000_0000;
    case (regIdx)
      adctr_pkg::IDX_CHAN0_RESULT_LOW:
      begin
        rdData[7:0] = adctr_pkg::LOW_UNUSED_ONES;
        rdData[adctr_pkg::LOW_RESULT_MSB:adctr_pkg::LOW_RESULT_LSB] = resultQ[0][1:0]; // RL3
        rdData[adctr_pkg::LOW_FLAG_BIT] = storedFlagQ[0];
      end
      adctr_pkg::IDX_CHAN0_RESULT_HIGH:
        rdData[7:0] = resultQ[0][adctr_pkg::RESULT_W-1:adctr_pkg::HIGH_RESULT_SHIFT]; // RL4
      adctr_pkg::IDX_CHAN1_RESULT_LOW:
      begin
        if (NumChan > 1)
        begin
          rdData[7:0] = adctr_pkg::LOW_UNUSED_ONES;
          rdData[adctr_pkg::LOW_RESULT_MSB:adctr_pkg::LOW_RESULT_LSB] =
            resultQ[NumChan-1][1:0]; // RL3
          rdData[adctr_pkg::LOW_FLAG_BIT] = storedFlagQ[NumChan-1];
        end
      end
      adctr_pkg::IDX_CHAN1_RESULT_HIGH:
      begin
        if (NumChan > 1)
          rdData[7:0] =
            resultQ[NumChan-1][adctr_pkg::RESULT_W-1:adctr_pkg::HIGH_RESULT_SHIFT]; // RL4
      end
      adctr_pkg::IDX_CONV_MODE_TWO:
        rdData[7:0] = modeTwoQ;
      adctr_pkg::IDX_IRQ_STATUS:
        rdData[adctr_pkg::IRQ_W-1:0] = irqStatusQ;
      adctr_pkg::IDX_IRQ_ENABLE:
        rdData[adctr_pkg::IRQ_W-1:0] = irqEnableQ;
      default:
        rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      datQ <= 32'h0000_0000;
    else if (access && !ackQ && !wbReq.we)
      datQ <= rdData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // result bits stay unknown until a first result, so layout checks wait for one
  logic                              chan0SeenQ;
  logic                              rdRequest;

  // the edge at which read data is captured
  assign rdRequest = access && !ackQ && !wbReq.we;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      chan0SeenQ <= 1'b0;
    else if (landed[0])
      chan0SeenQ <= 1'b1;
  end

  // bus handshake
  ack_answer_a : assert property (@(posedge sys_clk) disable iff (!resetn)
    access && !ackQ |=> wbAck)
    else $error("request not answered in the next cycle");

  ack_once_a : assert property (@(posedge sys_clk) disable iff (!resetn)
    wbAck |=> !wbAck)
    else $error("ack stood longer than one cycle");

  // trigger gating
  trig_start_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
    trigEdge && modeTwoQ[adctr_pkg::TRIG_ENABLE_BIT] |=> convStart)
    else $error("enabled trigger edge did not start a conversion");

  trig_gate_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
    trigEdge && !modeTwoQ[adctr_pkg::TRIG_ENABLE_BIT] |=> !convStart)
    else $error("trigger started a conversion while disabled");

  trig_fire_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
    convStart |-> $past(trigEdge) && $past(modeTwoQ[adctr_pkg::TRIG_ENABLE_BIT]))
    else $error("conversion start without an enabled trigger edge");

  low_bits_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL3
    rdRequest && regIdx == adctr_pkg::IDX_CHAN0_RESULT_LOW && chan0SeenQ
    |=> wbDatO[7:6] == $past(resultQ[0][1:0]) && wbDatO[5:1] == 5'h1F
        && wbDatO[0] == $past(storedFlagQ[0]))
    else $error("low register layout wrong");

  high_bits_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL4
    rdRequest && regIdx == adctr_pkg::IDX_CHAN0_RESULT_HIGH && chan0SeenQ
    |=> wbDatO[7:0] == $past(resultQ[0][9:2]))
    else $error("high register does not hold result bits 9 to 2");

  flag_set_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL5
    landed[0] |=> storedFlagQ[0] [*1])
    else $error("stored flag not set by new result");

  flag_clear_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL6
    pairRead[0] && !landed[0] |=> !storedFlagQ[0])
    else $error("pair read did not clear stored flag");

  flag_hold_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL7
    !storedFlagQ[0] && !landed[0] |=> !storedFlagQ[0])
    else $error("stored flag rose without a result");

  mode_unused_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL7
    ackQ && !wbReq.we && regIdx == adctr_pkg::IDX_CONV_MODE_TWO |-> wbDatO[7:1] == 7'h00)
    else $error("unused mode bits read nonzero");

  // bits 7:1 are not storage; only the enable follows writes
  mode_write_a : assert property (@(posedge sys_clk) disable iff (!resetn) // RL1
    wrStrobe && wbReq.sel[0] && regIdx == adctr_pkg::IDX_CONV_MODE_TWO
    |=> extTriggerEnable == $past(wbReq.dat[adctr_pkg::TRIG_ENABLE_BIT]))
    else $error("trigger enable bit did not take the written value");

  // interrupt status
  irq_set_a : assert property (@(posedge sys_clk) disable iff (!resetn)
    landed[0] |=> irqStatusQ[0])
    else $error("result event did not set its status bit");

  irq_clear_a : assert property (@(posedge sys_clk) disable iff (!resetn)
    irqClear[0] && !irqEvent[0] |=> !irqStatusQ[0])
    else $error("status bit survived its clear");

  trig_start_c : cover property (@(posedge sys_clk) disable iff (!resetn)
    trigEdge && modeTwoQ[0] ##1 convStart);

  read_clear_c : cover property (@(posedge sys_clk) disable iff (!resetn)
    storedFlagQ[0] && pairRead[0] ##1 !storedFlagQ[0]);

  set_over_clear_c : cover property (@(posedge sys_clk) disable iff (!resetn)
    landed[0] && pairRead[0]);

  irq_raise_c : cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq));

  chan1_clear_c : cover property (@(posedge sys_clk) disable iff (!resetn)
    storedFlagQ[NumChan-1] && pairRead[NumChan-1]);

endmodule : adctr_regs

`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the converter trigger and result register block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                     sys_clk;
  logic                     resetn;
  adctr_pkg::adctr_wb_req_t wbReq;
  logic [31:0]              wbDatO;
  logic                     wbAck;
  logic                     extTriggerPinN;
  logic                     convStart;
  adctr_pkg::adctr_result_t convResult;
  logic                     extTriggerEnable;
  logic                     irq;
  int                       failures;
  int                       num_checks;
  logic [31:0]              rd;
  int                       starts;

  adctr_regs #(.NumChan(2)) u_adctr_regs (
    .sys_clk(sys_clk), .resetn(resetn), .wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck),
    .extTriggerPinN(extTriggerPinN), .convStart(convStart), .convResult(convResult),
    .extTriggerEnable(extTriggerEnable), .irq(irq)
  );

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ack and read data are read right after the edge, before the slave updates
  task automatic wbXfer(input logic we, input logic [13:0] idx, input logic [7:0] wd,
                        output logic [31:0] rdat);
    @(posedge sys_clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: {idx, 2'b00}, dat: {24'h0, wd}};
    // only the watchdog ends a wait that never sees ack
    do
      @(posedge sys_clk);
    while (wbAck !== 1'b1);
    rdat = wbDatO;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    @(posedge sys_clk);
    chk(wbAck, 32'h0);
  endtask : wbXfer

  task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    wbXfer(1'b1, idx, wd, dummy);
  endtask : wr

  task automatic rdReg(input logic [13:0] idx, output logic [31:0] r);
    wbXfer(1'b0, idx, 8'h00, r);
  endtask : rdReg

  task automatic land(input logic ch, input logic [9:0] d);
    @(posedge sys_clk);
    convResult <= '{valid: 1'b1, channel: ch, data: d};
    @(posedge sys_clk);
    convResult.valid <= 1'b0;
  endtask : land

  // pin low for 8 cycles then high for 6, counting start pulses throughout
  task automatic pulseTrig(output int cnt);
    cnt = 0;
    @(posedge sys_clk);
    extTriggerPinN <= 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge sys_clk);
      if (convStart === 1'b1)
        cnt++;
      if (i == 7)
        extTriggerPinN <= 1'b1;
    end
  endtask : pulseTrig

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    @(negedge sys_clk);
    chk({wbAck, convStart, extTriggerEnable, irq}, 32'h0);
    chk(wbDatO, 32'h0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    rdReg(adctr_pkg::IDX_CONV_MODE_TWO, rd);
    chk(rd, 32'h00);
    rdReg(adctr_pkg::IDX_CHAN0_RESULT_LOW, rd);
    chk(rd & 32'h3F, 32'h3E);
    rdReg(adctr_pkg::IDX_CHAN1_RESULT_LOW, rd);
    chk(rd & 32'h3F, 32'h3E);
    $display("test reset done");
  endtask : test_reset

  task automatic test_trigger;
    pulseTrig(starts);
    chk(starts, 0);
    // channel code is driven outside this block; the bench never selects 1011
    wr(adctr_pkg::IDX_CONV_MODE_TWO, 8'hFF);
    rdReg(adctr_pkg::IDX_CONV_MODE_TWO, rd);
    chk(rd, 32'h01);
    chk(extTriggerEnable, 32'h1);
    pulseTrig(starts);
    chk(starts, 1);
    rdReg(adctr_pkg::IDX_IRQ_STATUS, rd);
    chk(rd & 32'h4, 32'h4);
    wr(adctr_pkg::IDX_IRQ_CLEAR, 8'h04);
    wr(adctr_pkg::IDX_CONV_MODE_TWO, 8'h00);
    pulseTrig(starts);
    chk(starts, 0);
    $display("test trigger done");
  endtask : test_trigger

  task automatic test_results;
    land(1'b0, 10'h2C5);
    wr(adctr_pkg::IDX_CHAN0_RESULT_HIGH, 8'h00);
    rdReg(adctr_pkg::IDX_CHAN0_RESULT_LOW, rd);
    chk(rd, 32'h7F);
    rdReg(adctr_pkg::IDX_CHAN0_RESULT_HIGH, rd);
    chk(rd, 32'hB1);
    rdReg(adctr_pkg::IDX_CHAN0_RESULT_LOW, rd);
    chk(rd, 32'h7E);
    land(1'b1, 10'h13A);
    rdReg(adctr_pkg::IDX_CHAN1_RESULT_HIGH, rd);
    chk(rd, 32'h4E);
    rdReg(adctr_pkg::IDX_CHAN1_RESULT_LOW, rd);
    chk(rd, 32'hBE);
    rdReg(14'h0100, rd);
    chk(rd, 32'h0);
    $display("test results done");
  endtask : test_results

  task automatic test_irq;
    wr(adctr_pkg::IDX_IRQ_CLEAR, 8'h07);
    wr(adctr_pkg::IDX_IRQ_ENABLE, 8'h03);
    rdReg(adctr_pkg::IDX_IRQ_ENABLE, rd);
    chk(rd, 32'h3);
    @(negedge sys_clk);
    chk(irq, 32'h0);
    land(1'b1, 10'h3FF);
    @(negedge sys_clk);
    chk(irq, 32'h1);
    rdReg(adctr_pkg::IDX_IRQ_STATUS, rd);
    chk(rd, 32'h2);
    wr(adctr_pkg::IDX_IRQ_CLEAR, 8'h02);
    @(negedge sys_clk);
    chk(irq, 32'h0);
    wr(adctr_pkg::IDX_IRQ_ENABLE, 8'h00);
    land(1'b0, 10'h000);
    @(negedge sys_clk);
    chk(irq, 32'h0);
    rdReg(adctr_pkg::IDX_IRQ_STATUS, rd);
    chk(rd, 32'h1);
    rdReg(adctr_pkg::IDX_CHAN0_RESULT_LOW, rd);
    chk(rd, 32'h3F);
    $display("test irq done");
  endtask : test_irq

  // channel 1 flag and status bit 0 are still set here
  task automatic test_midreset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    rdReg(adctr_pkg::IDX_CHAN1_RESULT_LOW, rd);
    chk(rd & 32'h3F, 32'h3E);
    rdReg(adctr_pkg::IDX_IRQ_STATUS, rd);
    chk(rd, 32'h0);
    $display("test midreset done");
  endtask : test_midreset

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk        = 1'b0;
    resetn         = 1'b0;
    wbReq          = '0;
    extTriggerPinN = 1'b1;
    convResult     = '0;
    failures       = 0;
    num_checks     = 0;
    repeat (4) @(posedge sys_clk);
    test_reset();
    test_trigger();
    test_results();
    test_irq();
    test_midreset();
    final_report();
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
